// ---- hsac_alert_status.v ----
// Status byte, alert latches, open-drain alert pin and serial register port.
`timescale 1ns/1ps
`include "hsac_map.vh"

module hsac_alert_status (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Serial bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    input  wire [6:0]  dev_addr,
    // Turn-on pin
    input  wire        on_pin,
    // Converter results
    input  wire        conv_done,
    input  wire [11:0] conv_current,
    // Hot swap controller state
    input  wire        latch_off_variant,
    input  wire        analog_trip_off_state,
    input  wire        insertion_fail_event,
    output reg         hotswap_off_request,
    // Alert pin
    output reg         alert_pin_n_out,
    output reg         alert_pin_n_oe
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RD   = 3'h5;
    localparam ST_RACK = 3'h6;

    // ==================================================================
    // Pin synchronisation
    wire [2:0] pins_s;
    wire [2:0] pins_p;

    hsac_sync #(
        .W (3)
    ) hsac_sync_i (
        .clk      (clk),
        .reset    (reset),
        .pin_raw  ({on_pin, sda_in, scl_in}),
        .pin_sync (pins_s),
        .pin_prev (pins_p)
    );

    wire scl_s     = pins_s[0];
    wire sda_s     = pins_s[1];
    wire on_s      = pins_s[2];
    wire scl_rise  = scl_s & ~pins_p[0];
    wire scl_fall  = ~scl_s & pins_p[0];
    wire bus_start = scl_s & pins_p[0] & pins_p[1] & ~sda_s;
    wire bus_stop  = scl_s & pins_p[0] & ~pins_p[1] & sda_s;

    // ==================================================================
    // Registers
    reg [3:0]  alert_en;
    reg [7:0]  alert_threshold_reg;
    reg        software_off_bit;
    reg        digital_overcurrent_now;
    reg        adc_alert_latched;
    reg        insertion_fail_latched;
    reg        off_alert_latched;
    reg [2:0]  oc_history;
    reg [2:0]  oc_run;
    reg        off_cond_d;
    reg [7:0]  alert_status_byte;

    wire single_conv_trip_enable = alert_en[`HSAC_EN_SINGLE];
    wire four_conv_trip_enable   = alert_en[`HSAC_EN_FOUR];
    wire insertion_fail_enable   = alert_en[`HSAC_EN_INSFAIL];
    wire off_alert_enable        = alert_en[`HSAC_EN_OFF];

    // Register write strobe from the serial engine.
    reg        reg_wr;
    reg [6:0]  reg_ptr;
    reg [7:0]  reg_wdata;

    wire clear_req = reg_wr && (reg_ptr == `HSAC_IDX_ALERT_EN)
                     && reg_wdata[`HSAC_EN_CLEAR];

    // ==================================================================
    // Threshold comparison
    wire over_th = conv_current[11:4] > alert_threshold_reg;

    wire [2:0] next_oc_history = {oc_history[1:0], over_th};
    wire [2:0] next_oc_run = !over_th ? 3'h0 :
                             (oc_run == `HSAC_RUN_MAX) ? oc_run : oc_run + 3'h1;

    wire adc_trip = conv_done && ((single_conv_trip_enable && over_th) ||
                    (four_conv_trip_enable && next_oc_run == `HSAC_RUN_MAX));

    wire off_cond  = ~on_s | software_off_bit;
    wire off_event = off_cond & ~off_cond_d;

    // ==================================================================
    // Register file and alert latches
    always @(posedge clk) begin
        if (reset) begin
            alert_en                <= `HSAC_ALERT_EN_RESET;
            alert_threshold_reg     <= `HSAC_THRESH_RESET;
            software_off_bit        <= 1'b0;
            digital_overcurrent_now <= 1'b0;
            adc_alert_latched       <= 1'b0;
            insertion_fail_latched  <= 1'b0;
            off_alert_latched       <= 1'b0;
            oc_history              <= 3'h0;
            oc_run                  <= 3'h0;
            off_cond_d              <= 1'b0;
        end else begin
            off_cond_d <= off_cond;
            if (reg_wr) begin
                case (reg_ptr)
                    `HSAC_IDX_ALERT_EN: begin
                        alert_en <= reg_wdata[3:0];
                    end
                    `HSAC_IDX_THRESH: begin
                        alert_threshold_reg <= reg_wdata;
                    end
                    `HSAC_IDX_CONTROL: begin
                        software_off_bit <= reg_wdata[`HSAC_CTRL_SOFT_OFF];
                    end
                    default: begin
                    end
                endcase
            end
            if (conv_done) begin
                oc_history              <= next_oc_history;
                oc_run                  <= next_oc_run;
                digital_overcurrent_now <= &next_oc_history;
            end
            // Set wins over a clear arriving in the same cycle.
            if (adc_trip) begin
                adc_alert_latched <= 1'b1;
            end else if (clear_req) begin
                adc_alert_latched <= 1'b0;
            end
            if (insertion_fail_event && insertion_fail_enable) begin
                insertion_fail_latched <= 1'b1;
            end else if (clear_req) begin
                insertion_fail_latched <= 1'b0;
            end
            if (off_event && off_alert_enable) begin
                off_alert_latched <= 1'b1;
            end else if (clear_req) begin
                off_alert_latched <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Status byte and alert pin
    wire trip_off_bit = (latch_off_variant && insertion_fail_enable) ?
                        insertion_fail_latched :
                        analog_trip_off_state;

    wire alert_active = (adc_alert_latched && (single_conv_trip_enable ||
                         four_conv_trip_enable)) ||
                        (insertion_fail_latched && insertion_fail_enable) ||
                        (off_alert_latched && off_alert_enable);

    always @(posedge clk) begin
        if (reset) begin
            alert_status_byte   <= 8'h00;
            alert_pin_n_out     <= 1'b0;
            alert_pin_n_oe      <= 1'b0;
            hotswap_off_request <= 1'b0;
        end else begin
            alert_status_byte   <= {2'b00,
                                    off_alert_latched,
                                    off_cond,
                                    insertion_fail_latched,
                                    trip_off_bit,
                                    adc_alert_latched,
                                    digital_overcurrent_now};
            alert_pin_n_out     <= 1'b0;
            alert_pin_n_oe      <= alert_active;
            hotswap_off_request <= off_cond;
        end
    end

    // ==================================================================
    // Serial slave engine
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx_shift;
    reg [7:0] tx_shift;
    reg       rd_mode;
    reg       first_byte;
    reg       master_ack;

    always @(posedge clk) begin
        if (reset) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            rx_shift   <= 8'h00;
            tx_shift   <= 8'h00;
            rd_mode    <= 1'b0;
            first_byte <= 1'b0;
            master_ack <= 1'b0;
            sda_out    <= 1'b0;
            sda_oe     <= 1'b0;
            reg_wr     <= 1'b0;
            reg_ptr    <= 7'h00;
            reg_wdata  <= 8'h00;
        end else begin
            reg_wr  <= 1'b0;
            sda_out <= 1'b0;
            if (bus_start) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (bus_stop) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state == ST_RACK) begin
                    master_ack <= ~sda_s;
                end else if (state != ST_IDLE) begin
                    rx_shift <= {rx_shift[6:0], sda_s};
                    bit_cnt  <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == `HSAC_BITS_PER_BYTE) begin
                            if (rx_shift[7:1] == dev_addr) begin
                                rd_mode <= rx_shift[0];
                                sda_oe  <= 1'b1;
                                state   <= ST_AACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bit_cnt    <= 4'h0;
                        first_byte <= 1'b1;
                        if (rd_mode) begin
                            sda_oe   <= ~alert_status_byte[7];
                            tx_shift <= {alert_status_byte[6:0], 1'b0};
                            state    <= ST_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_WR;
                        end
                    end
                    ST_WR: begin
                        if (bit_cnt == `HSAC_BITS_PER_BYTE) begin
                            sda_oe     <= 1'b1;
                            state      <= ST_WACK;
                            first_byte <= 1'b0;
                            if (first_byte) begin
                                reg_ptr <= rx_shift[6:0];
                            end else begin
                                reg_wdata <= rx_shift;
                                reg_wr    <= 1'b1;
                            end
                        end
                    end
                    ST_WACK: begin
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= ST_WR;
                    end
                    ST_RD: begin
                        if (bit_cnt == `HSAC_BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            state  <= ST_RACK;
                        end else begin
                            sda_oe   <= ~tx_shift[7];
                            tx_shift <= {tx_shift[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        bit_cnt <= 4'h0;
                        if (master_ack) begin
                            sda_oe   <= ~alert_status_byte[7];
                            tx_shift <= {alert_status_byte[6:0], 1'b0};
                            state    <= ST_RD;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ---- hsac_map.vh ----
// Register indices, field positions, reset values and bus codes of the alert status block.
`ifndef HSAC_MAP_VH
`define HSAC_MAP_VH

// ==================================================================
// Extended register indices
`define HSAC_IDX_ALERT_EN      7'h01
`define HSAC_IDX_THRESH        7'h02
`define HSAC_IDX_CONTROL       7'h03

// ==================================================================
// Alert-enable fields
`define HSAC_EN_SINGLE         0
`define HSAC_EN_FOUR           1
`define HSAC_EN_INSFAIL        2
`define HSAC_EN_OFF            3
`define HSAC_EN_CLEAR          4
`define HSAC_ALERT_EN_RESET    4'h4

// ==================================================================
// Threshold and control
`define HSAC_THRESH_RESET      8'hFF
`define HSAC_CTRL_SOFT_OFF     0

// ==================================================================
// Status byte fields
`define HSAC_ST_DIG_OC         0
`define HSAC_ST_ADC_ALERT      1
`define HSAC_ST_TRIP_OFF       2
`define HSAC_ST_FAIL_LATCH     3
`define HSAC_ST_OFF_STATUS     4
`define HSAC_ST_OFF_ALERT      5

// ==================================================================
// Conversion history
`define HSAC_RUN_MAX           3'h4
`define HSAC_OC_RUN            3'h3

// ==================================================================
// Serial engine
`define HSAC_BITS_PER_BYTE     4'h8
`endif

// ---- hsac_sync.v ----
// Two-flop synchroniser with edge history for pins entering the clock domain.
`timescale 1ns/1ps

module hsac_sync #(
    parameter W = 3
) (
    // Clock and reset
    input  wire         clk,
    input  wire         reset,
    // Raw pins
    input  wire [W-1:0] pin_raw,
    // Synchronised level and its previous value
    output reg  [W-1:0] pin_sync,
    output reg  [W-1:0] pin_prev
);

    reg [W-1:0] stage1;

    // ==================================================================
    // Synchronising stages
    always @(posedge clk) begin
        if (reset) begin
            stage1   <= {W{1'b1}};
            pin_sync <= {W{1'b1}};
            pin_prev <= {W{1'b1}};
        end else begin
            stage1   <= pin_raw;
            pin_sync <= stage1;
            pin_prev <= pin_sync;
        end
    end

endmodule

// ---- hsac_alert_status_checker.sv ----
// Port checker for the alert status block, bound to its top module.
`timescale 1ns/1ps

module hsac_alert_status_checker (
    // Clock and reset
    input wire        clk,
    input wire        reset,
    // Serial bus pins
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe,
    input wire [6:0]  dev_addr,
    // Pins and events
    input wire        on_pin,
    input wire        conv_done,
    input wire [11:0] conv_current,
    input wire        latch_off_variant,
    input wire        analog_trip_off_state,
    input wire        insertion_fail_event,
    input wire        hotswap_off_request,
    // Alert pin
    input wire        alert_pin_n_out,
    input wire        alert_pin_n_oe
);
    // ==================================================================
    // Helper logic
    // Counts cycles since the bus clock last rose, so host writes can be told apart.
    reg       scl_last;
    reg [5:0] since_rise;
    always @(posedge clk) begin
        scl_last <= scl_in;
        if (reset || (scl_in && !scl_last)) begin
            since_rise <= 6'h00;
        end else if (since_rise != 6'h3F) begin
            since_rise <= since_rise + 6'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ==================================================================
    // Assertions
    reset_quiet_a: assert property (disable iff (1'b0)
        reset |=> !alert_pin_n_oe && !sda_oe && !hotswap_off_request)
        else $error("Outputs active after reset.");
    alert_drive_a: assert property (alert_pin_n_out == 1'b0)
        else $error("Alert pin driven high.");
    sda_drive_a: assert property (sda_out == 1'b0)
        else $error("Data pin driven high.");
    sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("Data line changed while bus clock high.");
    sda_idle_a: assert property (scl_in && since_rise > 6'h27 |-> !sda_oe)
        else $error("Data line held on an idle bus.");
    off_pin_a: assert property (!on_pin [*5] |-> hotswap_off_request)
        else $error("Off request missing while turn-on pin low.");
    alert_fall_a: assert property ($fell(alert_pin_n_oe) |-> since_rise < 6'h28)
        else $error("Alert released without a host write.");
    alert_cause_a: assert property ($rose(alert_pin_n_oe) |->
        $past(conv_done, 2) || $past(insertion_fail_event, 2) ||
        $past(hotswap_off_request) || since_rise < 6'h28)
        else $error("Alert raised without a cause.");

    cover property ($rose(alert_pin_n_oe));
    cover property ($rose(sda_oe));
    cover property ($rose(hotswap_off_request));
endmodule

bind hsac_alert_status hsac_alert_status_checker hsac_alert_status_checker_i (
    .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(dev_addr), .on_pin(on_pin), .conv_done(conv_done),
    .conv_current(conv_current), .latch_off_variant(latch_off_variant),
    .analog_trip_off_state(analog_trip_off_state),
    .insertion_fail_event(insertion_fail_event), .hotswap_off_request(hotswap_off_request),
    .alert_pin_n_out(alert_pin_n_out), .alert_pin_n_oe(alert_pin_n_oe));

// ---- hsac_host_model.sv ----
// Serial bus host model that reaches the block's registers and status byte.
`timescale 1ns/1ps

module hsac_host_model (
    // Bus lines
    output logic scl,
    output logic sda_low,
    input  wire  sda,
    // Missing acknowledges seen
    output int   ack_miss
);
    localparam real QTR = 31.25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ack_miss = 0;
    end
    task automatic put_bit(input logic b);
        sda_low = !b;
        #QTR scl = 1'b1;
        #(2*QTR) scl = 1'b0;
        #QTR;
    endtask
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR b = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    task automatic send_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        if (a) ack_miss++;
    endtask
    task automatic start_frame;
        sda_low = 1'b1;
        #(2*QTR) scl = 1'b0;
        #QTR;
    endtask
    task automatic stop_frame;
        sda_low = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b0;
        #(2*QTR);
    endtask
    // Pointer byte then data byte, as the register port expects.
    task automatic wr(input logic [6:0] addr, input logic [6:0] idx, input logic [7:0] d);
        start_frame();
        send_byte({addr, 1'b0});
        send_byte({1'b0, idx});
        send_byte(d);
        stop_frame();
    endtask
    task automatic rd(input logic [6:0] addr, output logic [7:0] d);
        start_frame();
        send_byte({addr, 1'b1});
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop_frame();
    endtask
    // Two status bytes in one frame, the host acknowledging the first.
    task automatic rd2(input logic [6:0] addr, output logic [15:0] d);
        start_frame();
        send_byte({addr, 1'b1});
        for (int i = 15; i >= 8; i--) get_bit(d[i]);
        put_bit(1'b0);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop_frame();
    endtask
endmodule

// ---- hsac_alert_status_test.sv ----
// Self-checking bench for the alert status block driven by a serial host model.
`timescale 1ns/1ps

module hsac_alert_status_test;
    // ==================================================================
    // Signals
    localparam logic [6:0] ADDR = 7'h4A;
    logic        clk;
    logic        reset;
    logic        on_pin;
    logic        conv_done;
    logic [11:0] conv_current;
    logic        latch_off_variant;
    logic        analog_trip_off_state;
    logic        insertion_fail_event;
    logic        scl;
    logic        sda_low;
    logic [7:0]  rd_val;
    logic [15:0] rd2_val;
    wire         sda_out;
    wire         sda_oe;
    wire         hotswap_off_request;
    wire         alert_pin_n_out;
    wire         alert_pin_n_oe;
    wire         sda_line = (sda_oe ? sda_out : 1'b1) & !sda_low;
    wire         alert_pin_n = alert_pin_n_oe ? alert_pin_n_out : 1'b1;
    int          err_count;
    int          num_checks;
    int          cycles;
    int          ack_miss;

    hsac_alert_status hsac_alert_status_i (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .dev_addr(ADDR), .on_pin(on_pin), .conv_done(conv_done),
        .conv_current(conv_current), .latch_off_variant(latch_off_variant),
        .analog_trip_off_state(analog_trip_off_state),
        .insertion_fail_event(insertion_fail_event),
        .hotswap_off_request(hotswap_off_request),
        .alert_pin_n_out(alert_pin_n_out), .alert_pin_n_oe(alert_pin_n_oe));
    hsac_host_model hsac_host_model_i (
        .scl(scl), .sda_low(sda_low), .sda(sda_line), .ack_miss(ack_miss));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            $display("[ERR] %0t run did not finish", $time);
            stop_test();
        end
    end

    // ==================================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic st(input logic [7:0] exp);
        hsac_host_model_i.rd(ADDR, rd_val);
        chk(rd_val, exp, "status");
    endtask
    task automatic al(input logic exp);
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, !alert_pin_n}, {7'h00, exp}, "alert");
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        hsac_host_model_i.wr(ADDR, idx, d);
    endtask
    task automatic conv(input logic [11:0] v);
        @(posedge clk) #1 conv_done = 1'b1;
        conv_current = v;
        @(posedge clk) #1 conv_done = 1'b0;
    endtask
    task automatic fail_pulse;
        @(posedge clk) #1 insertion_fail_event = 1'b1;
        @(posedge clk) #1 insertion_fail_event = 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        on_pin = 1'b1;
        conv_done = 1'b0;
        conv_current = 12'h000;
        latch_off_variant = 1'b1;
        analog_trip_off_state = 1'b0;
        insertion_fail_event = 1'b0;
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        repeat (5) @(posedge clk);
        st(8'h00);
        al(1'b0);
        @(posedge clk) #1 on_pin = 1'b0;
        st(8'h10);
        al(1'b0);
        @(posedge clk) #1 on_pin = 1'b1;
        wr(7'h01, 8'h0C);
        wr(7'h03, 8'h01);
        st(8'h30);
        al(1'b1);
        wr(7'h03, 8'h00);
        st(8'h20);
        wr(7'h01, 8'h1C);
        st(8'h00);
        al(1'b0);
        fail_pulse();
        st(8'h0C);
        @(posedge clk) #1 latch_off_variant = 1'b0;
        st(8'h08);
        @(posedge clk) #1 analog_trip_off_state = 1'b1;
        st(8'h0C);
        @(posedge clk) #1 analog_trip_off_state = 1'b0;
        latch_off_variant = 1'b1;
        wr(7'h01, 8'h00);
        fail_pulse();
        st(8'h08);
        al(1'b0);
        wr(7'h01, 8'h15);
        st(8'h00);
        conv(12'hFFF);
        al(1'b0);
        wr(7'h02, 8'h80);
        conv(12'h800);
        al(1'b0);
        conv(12'h810);
        al(1'b1);
        st(8'h02);
        wr(7'h01, 8'h11);
        al(1'b0);
        wr(7'h01, 8'h02);
        conv(12'h000);
        conv(12'hFFF);
        conv(12'hFFF);
        st(8'h00);
        conv(12'hFFF);
        st(8'h01);
        al(1'b0);
        conv(12'hFFF);
        al(1'b1);
        st(8'h03);
        wr(7'h01, 8'h12);
        st(8'h01);
        conv(12'h000);
        st(8'h00);
        wr(7'h05, 8'h08);
        @(posedge clk) #1 on_pin = 1'b0;
        hsac_host_model_i.rd2(ADDR, rd2_val);
        chk(rd2_val[15:8], 8'h10, "first of two");
        chk(rd2_val[7:0], 8'h10, "second of two");
        al(1'b0);
        hsac_host_model_i.rd(7'h4B, rd_val);
        chk(rd_val, 8'hFF, "foreign read");
        chk(8'(ack_miss), 8'h01, "acks");
        stop_test();
    end
endmodule
